/* codec_port_pkg.sv */
/*
 * shared constants for the codec two-wire control port: control register
 * layout, start-stop word fields, i2c mode codes, host timing and offsets.
 * assumes a 250 MHz hclk on both ends.
 */
package codec_port_pkg;
    localparam int NREG = 6;
    typedef logic [NREG-1:0][7:0] ctrl_file_t;
    localparam logic [2:0] IDX_MIN = 3'h1;
    localparam logic [2:0] IDX_MAX = 3'h6;
    localparam int REG2_POS = 1;
    localparam int REG4_POS = 3;
    localparam ctrl_file_t REG_RESET = {8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
    localparam int PROTO_SEL_LSB = 0;
    localparam logic [1:0] PROTO_START_STOP = 2'h1;
    localparam int BUS_ADDR_LSB = 2;
    localparam int HOST_ENABLE_BIT = 7;
    localparam int GPIO_OUT_BIT = 1;
    localparam int GPIO_IN_BIT = 0;
    localparam logic [14:0] SS_BCAST_ON = 15'h78ff;
    localparam logic [14:0] SS_BCAST_OFF = 15'h7800;
    localparam int SS_ADDR_LSB = 11;
    localparam int SS_REG_LSB = 8;
    localparam logic [3:0] SS_LAST_BIT = 4'he;
    localparam logic [4:0] MODE_BCAST = 5'h1f;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam int CLK_MHZ = 250;
    localparam int SCL_QUARTER_NS = 625;
    localparam logic [8:0] SCL_QUARTER_CYC = 9'((SCL_QUARTER_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_WORD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    typedef enum logic [1:0] {OP_SS, OP_WR, OP_RD} op_t;
    typedef enum logic [2:0] {S_START, S_TX, S_RX, S_STOP, S_SS, S_END} step_t;
    localparam logic [4:0] BITS_COND = 5'h1;
    localparam logic [4:0] BITS_BYTE = 5'h9;
    localparam logic [4:0] BITS_SS = 5'h11;
endpackage : codec_port_pkg

/* codec_link_if.sv */
/*
 * two-wire link between the host controller and the codec port.
 * sda is open drain with a pull-up resolved here; scl is driven by the host.
 */
`timescale 1ns/1ps
interface codec_link_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic sda;
    // wired-and with pull-up: a low wins whenever its enable is active
    assign sda = ~((~host_sda_oe_n & ~host_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));
    modport host (output scl, output host_sda_o, output host_sda_oe_n, input sda);
    modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface : codec_link_if

/* codec_host_control_port.sv */
/*
 * codec end of the two-wire host port: control registers, start-stop and
 * i2c slave engines, cascade address, gpio fallback.
 * assumes scl and sda arrive asynchronously and toggle far slower than hclk;
 * cascade position and size come from the frame chain logic on hclk.
 */
// Behaviour
// - host writes all six control registers
// - start-stop write only, i2c read-write
// - host disabled means pins are gpio, except when start-stop is picked
// - device address equals cascade position
// - master address is count minus one
// - answer only own device address
// - control register 2 low bits 01 pick start-stop
// - host idles high, start low, stop high
// - start-stop magic word enables broadcast
// - broadcast ignores address bits of writes
// - start-stop magic word disables broadcast
// - i2c write: address, mode/index, data
// - i2c read: stop-start, address with read bit
// - index increments after every access
// - writes continue until stop or restart
// - mode 00000 default, 11111 broadcast
// - only address 0000 acks first and broadcast; code: a read address byte is acked by the addressed device
// - two write bytes then stop set index
// - i2c bus address field in register 2
`timescale 1ns/1ps
module codec_host_control_port
    import codec_port_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic [3:0] cascade_position,
    input wire logic [4:0] cascade_total,
    input wire logic cascade_is_master,
    output codec_port_pkg::ctrl_file_t ctrl_regs,
    output logic [3:0] device_address,
    codec_link_if.device link
);
    import codec_port_pkg::*;

    typedef enum logic [2:0] {D_IDLE, D_SS, D_ADDR, D_MODE, D_WDATA, D_RDATA, D_WAIT} dev_state_t;

    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_d;
        logic sda_m;
        logic sda_s;
        logic sda_d;
        dev_state_t st;
        dev_state_t nxt;
        logic [3:0] cnt;
        logic [15:0] sh;
        logic [2:0] idx;
        logic sel;
        logic bcast;
        logic bcast_ss;
        logic ack_en;
        logic sda_oe_n;
        logic [3:0] dev_addr;
        ctrl_file_t regs;
    } dev_t;

    dev_t s;
    dev_t next_s;

    function automatic logic idx_ok(input logic [2:0] i);
        return (i >= IDX_MIN) && (i <= IDX_MAX);
    endfunction : idx_ok

    // all behaviour in one next-state process
    always_comb begin
        logic rise;
        logic fall;
        logic start;
        logic stop;
        logic up;
        logic dev0;
        logic [7:0] b;
        logic [14:0] w;
        next_s = s;
        // two-flop synchronisers; edges look only at the second stage onward
        next_s.scl_m = link.scl;
        next_s.scl_s = s.scl_m;
        next_s.scl_d = s.scl_s;
        next_s.sda_m = link.sda;
        next_s.sda_s = s.sda_m;
        next_s.sda_d = s.sda_s;
        rise = s.scl_s & ~s.scl_d;
        fall = ~s.scl_s & s.scl_d;
        start = s.scl_s & s.scl_d & s.sda_d & ~s.sda_s;
        stop = s.scl_s & s.scl_d & ~s.sda_d & s.sda_s;
        b = {s.sh[6:0], s.sda_s};
        w = {s.sh[13:0], s.sda_s};
        up = b[7:5] == s.regs[REG2_POS][BUS_ADDR_LSB +: 3];
        dev0 = s.dev_addr == 4'h0;
        // address follows the detected chain; master sits at the top
        next_s.dev_addr = cascade_is_master ? 4'(cascade_total - 5'h1)
                                            : cascade_position;
        if (s.regs[REG2_POS][PROTO_SEL_LSB +: 2] == PROTO_START_STOP) begin
            // start-stop: frame is a low start bit then 15 bits, msb first
            next_s.sda_oe_n = 1'b1;
            if (s.st != D_SS) begin
                next_s.st = D_IDLE;
                if (rise && !s.sda_s) begin
                    next_s.st = D_SS;
                    next_s.cnt = 4'h0;
                end
            end else if (rise) begin
                next_s.sh = {s.sh[14:0], s.sda_s};
                next_s.cnt = s.cnt + 4'h1;
                if (s.cnt == SS_LAST_BIT) begin
                    next_s.st = D_IDLE;
                    if (w == SS_BCAST_ON) begin
                        next_s.bcast_ss = 1'b1;
                    end else if (w == SS_BCAST_OFF) begin
                        next_s.bcast_ss = 1'b0;
                    end else if ((s.bcast_ss
                                  || w[SS_ADDR_LSB +: 4] == s.dev_addr)
                                 && idx_ok(w[SS_REG_LSB +: 3])) begin
                        next_s.regs[w[SS_REG_LSB +: 3] - IDX_MIN] = w[7:0];
                    end
                end
            end
        end else if (!s.regs[REG4_POS][HOST_ENABLE_BIT]) begin
            // gpio: sda is an output, scl is read back into bit 0
            next_s.st = D_IDLE;
            next_s.sda_oe_n = s.regs[REG4_POS][GPIO_OUT_BIT];
            next_s.regs[REG4_POS][GPIO_IN_BIT] = s.scl_s;
        end else if (stop) begin
            next_s.st = D_IDLE;
            next_s.sda_oe_n = 1'b1;
        end else if (start) begin
            next_s.st = D_ADDR;
            next_s.cnt = 4'h0;
            next_s.sda_oe_n = 1'b1;
        end else if (s.st != D_IDLE && s.st != D_WAIT && s.st != D_SS) begin
            if (fall) begin
                if (s.st == D_RDATA && s.cnt != ACK_SLOT) begin
                    next_s.sda_oe_n = s.sh[7];
                    next_s.sh = {s.sh[14:0], 1'b0};
                end else begin
                    next_s.sda_oe_n = !(s.cnt == ACK_SLOT && s.ack_en && s.st != D_RDATA);
                end
            end
            if (rise && s.cnt != ACK_SLOT) begin
                next_s.cnt = s.cnt + 4'h1;
                if (s.st != D_RDATA) begin
                    next_s.sh = {s.sh[14:0], s.sda_s};
                end
            end
            if (rise && s.cnt == LAST_DATA_BIT && s.st != D_RDATA) begin
                unique case (s.st)
                    D_ADDR: begin
                        next_s.sel = b[4:1] == s.dev_addr;
                        next_s.bcast = 1'b0;
                        if (!up || (b[0] && !next_s.sel)) begin
                            next_s.nxt = D_WAIT;
                            next_s.ack_en = 1'b0;
                        end else if (b[0]) begin
                            next_s.nxt = D_RDATA;
                            next_s.ack_en = 1'b1;
                        end else begin
                            next_s.nxt = D_MODE;
                            next_s.ack_en = dev0;
                        end
                    end
                    D_MODE: begin
                        next_s.bcast = b[7:3] == MODE_BCAST;
                        next_s.idx = b[2:0];
                        next_s.ack_en = next_s.bcast ? dev0 : s.sel;
                        next_s.nxt = (next_s.bcast || s.sel) ? D_WDATA : D_WAIT;
                    end
                    D_WDATA: begin
                        if (idx_ok(s.idx)) begin
                            next_s.regs[s.idx - IDX_MIN] = b;
                        end
                        next_s.idx = s.idx + 3'h1;
                        next_s.ack_en = s.bcast ? dev0 : s.sel;
                        next_s.nxt = D_WDATA;
                    end
                    default: begin
                        next_s.nxt = D_WAIT;
                    end
                endcase
            end
            if (rise && s.cnt == ACK_SLOT) begin
                next_s.cnt = 4'h0;
                next_s.st = s.nxt;
                if (s.nxt == D_RDATA) begin
                    if (s.st == D_RDATA && s.sda_s) begin
                        next_s.st = D_WAIT; // host nack ends the read
                    end else begin
                        next_s.sh = {8'h00, idx_ok(s.idx) ? s.regs[s.idx - IDX_MIN] : 8'h00};
                        next_s.idx = s.idx + 3'h1;
                    end
                end
            end
        end
    end

    // single state register; ce freezes everything
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '{st: D_IDLE, nxt: D_IDLE, regs: REG_RESET, sda_oe_n: 1'b1,
                   scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1,
                   sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1, default: '0};
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign ctrl_regs = s.regs;
    assign device_address = s.dev_addr;
    assign link.dev_sda_o = 1'b0; // open drain: only the enable moves
    assign link.dev_sda_oe_n = s.sda_oe_n;
endmodule : codec_host_control_port

/* codec_host_controller.sv */
/*
 * host end of the two-wire port: an ahb-lite slave whose command registers
 * run start-stop words, i2c single-byte writes and index-then-read reads.
 * assumes one ahb-lite master, word transfers, and a pull-up on sda.
 */
`timescale 1ns/1ps
module codec_host_controller
    import codec_port_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    codec_link_if.host link
);
    import codec_port_pkg::*;

    typedef struct packed {
        logic sda_m;
        logic sda_s;
        logic busy;
        logic nack;
        op_t op;
        logic [3:0] seq;
        logic [1:0] q;
        logic [4:0] bitn;
        logic [8:0] tmr;
        logic [23:0] word;
        logic [16:0] sh;
        logic [7:0] rbyte;
        logic scl;
        logic sda_oe_n;
        logic ph_wr;
        logic [7:0] ph_addr;
        logic [31:0] rdata;
    } host_t;

    host_t s;
    host_t next_s;

    // sequence of bus conditions for each command
    function automatic step_t step_of(input op_t op, input logic [3:0] seq);
        step_t t;
        t = S_END;
        unique case (op)
            OP_SS: t = (seq == 4'h0) ? S_SS : S_END;
            OP_WR: begin
                unique case (seq)
                    4'h0: t = S_START;
                    4'h1, 4'h2, 4'h3: t = S_TX;
                    4'h4: t = S_STOP;
                    default: t = S_END;
                endcase
            end
            OP_RD: begin
                unique case (seq)
                    4'h0, 4'h4: t = S_START;
                    4'h1, 4'h2, 4'h5: t = S_TX;
                    4'h3, 4'h7: t = S_STOP;
                    4'h6: t = S_RX;
                    default: t = S_END;
                endcase
            end
            default: t = S_END;
        endcase
        return t;
    endfunction : step_of

    // bits to shift out for a step; the ack slot is left released
    function automatic logic [16:0] load_of(input op_t op, input logic [3:0] seq,
                                            input logic [23:0] w);
        logic [7:0] by;
        by = 8'hff;
        unique case (seq)
            4'h1: by = {w[7:1], 1'b0};
            4'h2: by = w[15:8];
            4'h3: by = w[23:16];
            4'h5: by = {w[7:1], 1'b1};
            default: by = 8'hff;
        endcase
        if (op == OP_SS) begin
            return {1'b0, w[14:0], 1'b1};
        end
        return {by, 9'h1ff};
    endfunction : load_of

    // command engine and ahb slave in one next-state process
    always_comb begin
        step_t t;
        logic [4:0] nbits;
        next_s = s;
        next_s.sda_m = link.sda;
        next_s.sda_s = s.sda_m;
        t = step_of(s.op, s.seq);
        nbits = (t == S_SS) ? BITS_SS : (t == S_TX || t == S_RX) ? BITS_BYTE : BITS_COND;
        if (s.busy) begin
            next_s.tmr = s.tmr - 9'h1;
            if (s.tmr == 9'h0) begin
                next_s.tmr = SCL_QUARTER_CYC - 9'h1;
                next_s.q = s.q + 2'h1;
                unique case (s.q)
                    2'h0: begin
                        next_s.scl = 1'b0;
                        next_s.sda_oe_n = (t == S_START) ? 1'b1 : (t == S_STOP) ? 1'b0 : s.sh[16];
                    end
                    2'h1: next_s.scl = 1'b1;
                    2'h2: begin
                        if (t == S_START) begin
                            next_s.sda_oe_n = 1'b0;
                        end else if (t == S_STOP) begin
                            next_s.sda_oe_n = 1'b1;
                        end else if (t == S_TX && s.bitn == 5'h8) begin
                            next_s.nack = s.nack | s.sda_s;
                        end else if (t == S_RX && s.bitn < 5'h8) begin
                            next_s.rbyte = {s.rbyte[6:0], s.sda_s};
                        end
                    end
                    2'h3: begin
                        next_s.scl = (t == S_STOP);
                        next_s.sh = {s.sh[15:0], 1'b1};
                        next_s.bitn = s.bitn + 5'h1;
                        if (s.bitn == nbits - 5'h1) begin
                            next_s.bitn = 5'h0;
                            next_s.seq = s.seq + 4'h1;
                            next_s.sh = load_of(s.op, s.seq + 4'h1, s.word);
                            if (step_of(s.op, s.seq + 4'h1) == S_END) begin
                                next_s.busy = 1'b0;
                                next_s.scl = 1'b1;
                                next_s.sda_oe_n = 1'b1;
                            end
                        end
                    end
                endcase
            end
        end
        // ahb data phase: writes land here; ctrl starts a command when idle
        if (s.ph_wr) begin
            next_s.ph_wr = 1'b0;
            if (s.ph_addr == OFS_WORD) begin
                next_s.word = hwdata[23:0];
            end else if (s.ph_addr == OFS_CTRL && !s.busy && hwdata[1:0] != 2'h3) begin
                next_s.op = op_t'(hwdata[1:0]);
                next_s.busy = 1'b1;
                next_s.nack = 1'b0;
                next_s.seq = 4'h0;
                next_s.q = 2'h0;
                next_s.bitn = 5'h0;
                next_s.tmr = SCL_QUARTER_CYC - 9'h1;
                next_s.sh = load_of(op_t'(hwdata[1:0]), 4'h0, s.word);
            end
        end
        // ahb address phase: reads are answered in the next cycle, zero wait
        if (hsel && htrans[1] && hready) begin
            next_s.ph_wr = hwrite;
            next_s.ph_addr = haddr[7:0];
            if (!hwrite) begin
                unique case (haddr[7:0])
                    OFS_CTRL: next_s.rdata = {30'h0, s.op};
                    OFS_WORD: next_s.rdata = {8'h00, s.word};
                    OFS_STATUS: next_s.rdata = {16'h0, s.rbyte, 6'h0, s.nack, s.busy};
                    default: next_s.rdata = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '{op: OP_SS, sda_m: 1'b1, sda_s: 1'b1, scl: 1'b1, sda_oe_n: 1'b1,
                   sh: 17'h1ffff, default: '0};
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign hrdata = s.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign link.scl = s.scl;
    assign link.host_sda_o = 1'b0;
    assign link.host_sda_oe_n = s.sda_oe_n;
endmodule : codec_host_controller

/* codec_host_control_port_monitor.sv */
/*
 * wire checker for the codec two-wire link: scl phase length, who may move
 * sda and when, and how long the codec may hold sda low.
 * assumes it sits beside the link interface on hclk, reset async active low.
 */
`timescale 1ns/1ps
module codec_host_control_port_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic scl,
    input wire logic host_sda_oe_n,
    input wire logic dev_sda_oe_n,
    input wire logic dev_sda_o,
    input wire logic sda
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic [15:0] phase_cnt;
    logic [7:0] low_cnt;
    logic [15:0] dev_cnt;
    logic scl_q;

    // saturating counters; phase starts saturated so the first scl edge never fires
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_cnt <= 16'hffff;
            low_cnt <= 8'h00;
            dev_cnt <= 16'h0000;
            scl_q <= 1'b1;
        end else begin
            scl_q <= scl;
            phase_cnt <= (scl != scl_q) ? 16'h0000 : phase_cnt + {15'h0, phase_cnt != 16'hffff};
            low_cnt <= scl ? 8'h00 : low_cnt + {7'h0, low_cnt != 8'hff};
            dev_cnt <= dev_sda_oe_n ? 16'h0000 : dev_cnt + {15'h0, dev_cnt != 16'hffff};
        end
    end

    reset_idle_a: assert property ($rose(hresetn) |-> scl && sda)
        else $error("link not idle high after reset");
    scl_phase_a: assert property ((scl != scl_q) |-> phase_cnt >= 16'h0096)
        else $error("scl phase shorter than a quarter period");
    dev_edge_time_a: assert property ($changed(dev_sda_oe_n) |-> !scl && low_cnt inside {[8'h01:8'h0c]})
        else $error("codec moved sda outside the scl low window");
    dev_low_len_a: assert property (!dev_sda_oe_n |-> dev_cnt < 16'h1770)
        else $error("codec held sda low too long");
    start_by_host_a: assert property ($fell(sda) && scl |-> !host_sda_oe_n)
        else $error("start condition not made by host");
    stop_by_host_a: assert property ($rose(sda) && scl && $past(scl) |-> $rose(host_sda_oe_n))
        else $error("stop condition not made by host");
    dev_pull_low_a: assert property (!dev_sda_oe_n |-> !dev_sda_o ##1 (dev_sda_oe_n || !sda))
        else $error("codec drive does not pull sda low");
    host_release_a: assert property (!dev_sda_oe_n && scl |-> host_sda_oe_n)
        else $error("host drives sda while codec answers");

    ack_seen_c: cover property ($fell(dev_sda_oe_n));
    start_seen_c: cover property ($fell(sda) && scl);
    stop_seen_c: cover property ($rose(sda) && scl);
endmodule : codec_host_control_port_monitor

/* codec_host_control_port_tb.sv */
/*
 * self-checking bench: ahb-lite master drives the host controller, which
 * talks to the codec port over the shared link; registers judged at ports.
 * assumes 250 MHz hclk and codec at cascade address 0000 for i2c traffic.
 */
`timescale 1ns/1ps
module codec_host_control_port_tb;
    import codec_port_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic ce = 1'b1;
    logic [3:0] cascade_position = 4'h0;
    logic [4:0] cascade_total = 5'h02;
    logic cascade_is_master = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    ctrl_file_t ctrl_regs;
    ctrl_file_t exp;
    logic [3:0] device_address;
    logic [31:0] status;
    int err_count = 0;
    int checked = 0;

    codec_link_if codec_link_if_i ();
    codec_host_controller codec_host_controller_i (.hclk(hclk), .hresetn(hresetn), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .link(codec_link_if_i.host));
    codec_host_control_port codec_host_control_port_i (.hclk(hclk), .hresetn(hresetn),
        .ce(ce), .cascade_position(cascade_position), .cascade_total(cascade_total),
        .cascade_is_master(cascade_is_master), .ctrl_regs(ctrl_regs),
        .device_address(device_address), .link(codec_link_if_i.device));
    codec_host_control_port_monitor codec_host_control_port_monitor_i (.hclk(hclk),
        .hresetn(hresetn), .scl(codec_link_if_i.scl),
        .host_sda_oe_n(codec_link_if_i.host_sda_oe_n),
        .dev_sda_oe_n(codec_link_if_i.dev_sda_oe_n),
        .dev_sda_o(codec_link_if_i.dev_sda_o), .sda(codec_link_if_i.sda));

    // free-running 4 ns clock
    always #2 hclk = ~hclk;

    task automatic end_of_test();
        if (err_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [47:0] want, input logic [47:0] got);
        checked++;
        if (got !== want) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, want, got);
        end
    endtask : chk

    // one single word transfer; entered just after a rising edge
    task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, ofs};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 48'h0, {47'h0, hresp});
    endtask : ahb

    // load the word, start the command, poll busy; a command can take ~25k cycles
    task automatic run_op(input logic [1:0] op, input logic [31:0] word);
        logic [31:0] rd;
        int n;
        ahb(1'b1, OFS_WORD, word, rd);
        ahb(1'b1, OFS_CTRL, {30'h0, op}, rd);
        n = 0;
        do begin
            ahb(1'b0, OFS_STATUS, 32'h0, status);
            n++;
        end while (status[0] !== 1'b0 && n < 30000);
        chk("busy", 48'h0, {47'h0, status[0]});
    endtask : run_op

    task automatic reset_values();
        exp = REG_RESET;
        chk("ctrl_regs", exp, ctrl_regs);
        chk("device_address", 48'h0, {44'h0, device_address});
    endtask : reset_values

    // broadcast on, off-address write lands, off, off-address ignored, own lands
    task automatic ss_broadcast();
        run_op(2'(OP_SS), {17'h0, SS_BCAST_ON});
        chk("regs after bcast on", exp, ctrl_regs);
        run_op(2'(OP_SS), 32'h00007c80);
        exp[REG4_POS] = 8'h80;
        chk("regs bcast write", exp, ctrl_regs);
        run_op(2'(OP_SS), {17'h0, SS_BCAST_OFF});
        chk("regs after bcast off", exp, ctrl_regs);
        run_op(2'(OP_SS), 32'h00007a00);
        chk("regs foreign write", exp, ctrl_regs);
        run_op(2'(OP_SS), 32'h00000200);
        exp[REG2_POS] = 8'h00;
        chk("regs own write", exp, ctrl_regs);
    endtask : ss_broadcast

    // broadcast-mode write of register 5, then default-mode read of it
    task automatic i2c_write_read();
        run_op(2'(OP_WR), 32'h005afd00);
        exp[4] = 8'h5a;
        chk("regs i2c write", exp, ctrl_regs);
        chk("write nack", 48'h0, {47'h0, status[1]});
        run_op(2'(OP_RD), 32'h00000500);
        chk("read byte", 48'h5a, {40'h0, status[15:8]});
        chk("read nack", 48'h0, {47'h0, status[1]});
        chk("regs after read", exp, ctrl_regs);
    endtask : i2c_write_read

    // slave takes its position, master takes count minus one
    task automatic cascade_addr();
        cascade_position <= 4'h9;
        repeat (3) @(posedge hclk);
        chk("slave address", 48'h9, {44'h0, device_address});
        cascade_is_master <= 1'b1;
        cascade_total <= 5'h10;
        repeat (3) @(posedge hclk);
        chk("master address", 48'hf, {44'h0, device_address});
    endtask : cascade_addr

    // main sequence
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        reset_values();
        ss_broadcast();
        i2c_write_read();
        cascade_addr();
        end_of_test();
    end

    // watchdog: five start-stop frames plus one i2c write and one read need about 97k cycles
    initial begin
        repeat (105000) @(posedge hclk);
        err_count++;
        end_of_test();
    end
endmodule : codec_host_control_port_tb
